// *** dac_load_monitor.sv ***
// assertion checker for the converter load controller
`timescale 1ns/1ps
module dac_load_monitor (
  input wire logic        clk, reset_n, load_strobe_n, clear_n,
  input wire logic [11:0] dacCode, codeStream,
  input wire logic [12:0] outputMv,
  input wire logic        codeUpdate, codeStreamValid, codeStreamReady,
  input wire logic        overflow
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_clr_rel;
    (!clear_n && load_strobe_n) ##1 (clear_n && load_strobe_n)[*6];
  endsequence
  property p_mv; outputMv == {1'b0, dacCode}; endproperty
  a_mv: assert property (p_mv) else $error("mv");
  property p_clr; (!clear_n)[*5] |-> dacCode == 12'h000; endproperty
  a_clr: assert property (p_clr) else $error("clr");
  property p_hold; (load_strobe_n && clear_n)[*5] |=> $stable(dacCode);
  endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_latch; s_clr_rel |-> dacCode == 12'h000; endproperty
  a_latch: assert property (p_latch) else $error("latch");
  property p_upd; $changed(dacCode) |-> codeUpdate; endproperty
  a_upd: assert property (p_upd) else $error("upd");
  property p_valid; codeUpdate |-> ##2 (codeStreamValid || overflow);
  endproperty
  a_valid: assert property (p_valid) else $error("valid");
  property p_stall; codeStreamValid && !codeStreamReady
    |=> codeStreamValid && $stable(codeStream); endproperty
  a_stall: assert property (p_stall) else $error("stall");
  property p_ovf; overflow |=> overflow; endproperty
  a_ovf: assert property (p_ovf) else $error("ovf");
endmodule
bind serial_dac_load_control dac_load_monitor i_mon (.*);

// *** dac_load_pkg.sv ***
// constants for the serial converter load controller
package dac_load_pkg;
  localparam int          CODE_W      = 12;
  localparam int          FIFO_DEPTH  = 8;
  localparam logic [11:0] CODE_ZERO   = 12'h000;
  localparam logic [11:0] CODE_FULL   = 12'hFFF;
  localparam int          UV_PER_STEP = 1000;
  localparam int          MV_W        = 13;
  localparam int          SYNC_STAGES = 2;
endpackage

// *** host_model.sv ***
// host side of the pin link: shift clock, select and data
`timescale 1ns/1ps
module host_model (
  output logic shiftClk, select_n, serial_data_in
);
  initial begin
    shiftClk = 1'b1;
    select_n = 1'b1;
    serial_data_in = 1'b0;
  end
  task automatic send(input logic [15:0] v);
    select_n = 1'b0;
    #24;
    for (int i = 15; i >= 0; i--) begin
      shiftClk = 1'b0;
      serial_data_in = v[i];
      #24;
      shiftClk = 1'b1;
      #24;
    end
    // clock parked high so select rise adds no shift
    select_n = 1'b1;
    serial_data_in = ~serial_data_in;
  endtask
  // select used as the shift clock while the clock pin is parked low
  task automatic send_sel(input logic [15:0] v);
    shiftClk = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      select_n = 1'b0;
      serial_data_in = v[i];
      #24;
      select_n = 1'b1;
      #24;
    end
    // clock rises with select high, so no extra shift
    shiftClk = 1'b1;
  endtask
endmodule

// *** serial_dac_load_control.sv ***
// serial input register, load latch and clear for a 12-bit converter
`timescale 1ns/1ps
module serial_dac_load_control (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        shiftClk,
  input  wire logic        select_n,
  input  wire logic        serial_data_in,
  input  wire logic        load_strobe_n,
  input  wire logic        clear_n,
  output logic      [11:0] dacCode,
  output logic      [12:0] outputMv,
  output logic             codeUpdate,
  output logic      [11:0] codeStream,
  output logic             codeStreamValid,
  input  wire logic        codeStreamReady,
  output logic             overflow
);
  localparam int W = dac_load_pkg::CODE_W;

  logic [4:0] pins;
  logic [4:0] pinsS;
  logic       sclkS;
  logic       selS_n;
  logic       dinS;
  logic       loadS_n;
  logic       clrS_n;

  // every pin passes two flops before any logic looks at it
  sync_2ff #(
    .W (5)
  ) u_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .asyncIn (pins),
    .syncOut (pinsS)
  );

  assign pins    = {shiftClk, select_n, serial_data_in,
                    load_strobe_n, clear_n};
  assign sclkS   = pinsS[4];
  assign selS_n  = pinsS[3];
  assign dinS    = pinsS[2];
  assign loadS_n = pinsS[1];
  assign clrS_n  = pinsS[0];

  // previous synchronised levels for edge detection
  logic       sclkPrev_q;
  logic       sclkPrev_d;
  logic       selPrev_q;
  logic       selPrev_d;
  logic       shiftEdge;

  // serial shift register, separate from the converter register
  logic [W-1:0] shift_q;
  logic [W-1:0] shift_d;

  // converter register
  logic [W-1:0] dac_q;
  logic [W-1:0] dac_d;
  logic [12:0]  mv_q;
  logic [12:0]  mv_d;
  logic         upd_q;
  logic         upd_d;
  logic         ovf_q;
  logic         ovf_d;

  // fifo feed of every new converter code
  logic         fifoInReady;
  logic         fifoOutValid;
  logic [W-1:0] fifoOutData;
  logic         fifoOutReady;
  logic         pushCode;

  // holding stage in front of the stream ports, so they leave on flops;
  // it adds one slot, so nine codes can wait before one is dropped
  logic [W-1:0] head_q;
  logic [W-1:0] head_d;
  logic         headValid_q;
  logic         headValid_d;
  logic         headTake;
  logic         headLeave;

  // edge detection on the synchronised shift clock and select
  always_comb begin
    sclkPrev_d = sclkS;
    selPrev_d  = selS_n;
    // select and clock act alike: either rising while the other is low
    shiftEdge = (sclkS && !sclkPrev_q && !selS_n) ||
                (selS_n && !selPrev_q && !sclkS);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sclkPrev_q <= 1'b0;
      selPrev_q  <= 1'b1;
    end else begin
      sclkPrev_q <= sclkPrev_d;
      selPrev_q  <= selPrev_d;
    end
  end

  // serial shift register
  always_comb begin
    shift_d = shift_q;
    if (shiftEdge) begin
      // oldest bit drops off the top, new bit enters at the bottom
      shift_d = {shift_q[W-2:0], dinS};
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shift_q <= dac_load_pkg::CODE_ZERO;
    end else begin
      shift_q <= shift_d;
    end
  end

  // converter register
  always_comb begin
    dac_d = dac_q;
    if (!clrS_n) begin
      // clear wins over load; rising clear with load high leaves zeros held
      dac_d = dac_load_pkg::CODE_ZERO;
    end else if (!loadS_n) begin
      // transparent while low; shifting under a low strobe would leak
      // partial data onto the output, which the host must avoid
      dac_d = shift_q;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dac_q <= dac_load_pkg::CODE_ZERO;
    end else begin
      dac_q <= dac_d;
    end
  end

  // millivolt output
  always_comb begin
    // one code step is one millivolt, so the code is the millivolt figure
    mv_d = {1'b0, dac_d};
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mv_q <= '0;
    end else begin
      mv_q <= mv_d;
    end
  end

  // one-cycle pulse on every change of the converter code
  always_comb begin
    upd_d = (dac_d != dac_q);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      upd_q <= 1'b0;
    end else begin
      upd_q <= upd_d;
    end
  end

  // overflow flag
  always_comb begin
    pushCode = upd_q;
    // sticky until reset, so the consumer never misses a lost code
    ovf_d    = ovf_q || (pushCode && !fifoInReady);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ovf_q <= 1'b0;
    end else begin
      ovf_q <= ovf_d;
    end
  end

  // a full fifo drops the code and raises the sticky overflow flag;
  // the converter register itself can never be held back
  sync_fifo #(
    .WIDTH (W),
    .DEPTH (dac_load_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .reset_n  (reset_n),
    .inData   (dac_q),
    .inValid  (pushCode),
    .inReady  (fifoInReady),
    .outData  (fifoOutData),
    .outValid (fifoOutValid),
    .outReady (fifoOutReady)
  );

  // holding stage refills from the fifo whenever it is empty or taken
  always_comb begin
    headLeave    = headValid_q && codeStreamReady;
    fifoOutReady = !headValid_q || codeStreamReady;
    headTake     = fifoOutReady && fifoOutValid;
    head_d       = head_q;
    headValid_d  = headValid_q;
    if (headTake) begin
      head_d      = fifoOutData;
      headValid_d = 1'b1;
    end else if (headLeave) begin
      headValid_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      head_q      <= dac_load_pkg::CODE_ZERO;
      headValid_q <= 1'b0;
    end else begin
      head_q      <= head_d;
      headValid_q <= headValid_d;
    end
  end

  assign dacCode         = dac_q;
  assign outputMv        = mv_q;
  assign codeUpdate      = upd_q;
  assign codeStream      = head_q;
  assign codeStreamValid = headValid_q;
  assign overflow        = ovf_q;
endmodule

// *** sync_2ff.sv ***
// two-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
module sync_2ff #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = asyncIn;
    sync_d = meta_q;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign syncOut = sync_q;
endmodule

// *** sync_fifo.sv ***
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module sync_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    wr_d;
  logic [AW-1:0]    rd_q;
  logic [AW-1:0]    rd_d;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             push;
  logic             pop;

  always_comb begin
    push  = inValid && inReady;
    pop   = outValid && outReady;
    wr_d  = push ? AW'(wr_q + 1'b1) : wr_q;
    rd_d  = pop ? AW'(rd_q + 1'b1) : rd_q;
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = (AW+1)'(cnt_q + 1'b1);
    end else if (pop && !push) begin
      cnt_d = (AW+1)'(cnt_q - 1'b1);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // storage has no reset: contents are gated by the count
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= inData;
    end
  end

  assign inReady  = (cnt_q != (AW+1)'(DEPTH));
  assign outValid = (cnt_q != '0);
  assign outData  = mem[rd_q];
endmodule

// *** tb_top.sv ***
// self-checking bench for the converter load controller
`timescale 1ns/1ps
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin \
  errors++; $display("ERROR %s exp %h got %h", n, e, a); end end
module tb_top;
  logic        clk = 1'b0, reset_n = 1'b0, rdy = 1'b0;
  logic        load_strobe_n = 1'b1, clear_n = 1'b1;
  wire logic   shiftClk, select_n, sdata;
  logic [11:0] dacCode, codeStream, model = 12'h000, h;
  logic [12:0] outputMv;
  logic        codeUpdate, codeStreamValid, overflow;
  logic [15:0] v;
  logic [11:0] q[$];
  int          errors = 0, comparisons = 0, cycles = 0, pushes = 0;
  initial forever #2.5 clk = ~clk;
  host_model i_host_model (.shiftClk(shiftClk), .select_n(select_n),
    .serial_data_in(sdata));
  serial_dac_load_control i_serial_dac_load_control (.clk(clk),
    .reset_n(reset_n), .shiftClk(shiftClk), .select_n(select_n),
    .serial_data_in(sdata), .load_strobe_n(load_strobe_n),
    .clear_n(clear_n), .dacCode(dacCode), .outputMv(outputMv),
    .codeUpdate(codeUpdate), .codeStream(codeStream),
    .codeStreamValid(codeStreamValid), .codeStreamReady(rdy),
    .overflow(overflow));
  task automatic print_verdict();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      print_verdict();
    end
  end
  // pins held well past the two-flop sync delay
  task automatic drive(input logic ld, input logic cl);
    @(posedge clk);
    load_strobe_n <= ld;
    clear_n <= cl;
    repeat (8) @(posedge clk);
    @(negedge clk);
  endtask
  initial begin
    void'($urandom(32'h8BC3873C));
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(negedge clk);
    `CHK("reset code", 12'h000, dacCode)
    `CHK("reset valid", 1'b0, codeStreamValid)
    for (int k = 0; k < 11; k++) begin
      v = (k == 0) ? 16'h5FFF : (k == 1) ? 16'hA800 : 16'($urandom);
      if (k % 2 == 1) i_host_model.send_sel(v);
      else i_host_model.send(v);
      repeat (4) @(negedge clk);
      `CHK("held", model, dacCode)
      drive(1'b0, 1'b1);
      if (v[11:0] != model) begin
        pushes++;
        // the output holding stage keeps one code beyond the fifo depth
        if (q.size() < dac_load_pkg::FIFO_DEPTH + 1) q.push_back(v[11:0]);
      end
      model = v[11:0];
      `CHK("dacCode", model, dacCode)
      `CHK("outputMv", {1'b0, model}, outputMv)
      drive(1'b1, 1'b1);
    end
    `CHK("overflow", pushes > dac_load_pkg::FIFO_DEPTH + 1, overflow)
    for (int t = 0; t < 400 && q.size() > 0; t++) begin
      @(posedge clk) rdy <= 1'($urandom);
      @(negedge clk);
      if (codeStreamValid === 1'b1 && rdy) begin
        h = q.pop_front();
        `CHK("stream", h, codeStream)
      end
    end
    `CHK("drained", 0, q.size())
    drive(1'b0, 1'b0);
    `CHK("clear", 12'h000, dacCode)
    `CHK("zero mv", 13'h0000, outputMv)
    drive(1'b1, 1'b0);
    drive(1'b1, 1'b1);
    `CHK("latched", 12'h000, dacCode)
    print_verdict();
  end
endmodule
